// *** common/rsid_dec_if.sv ***
// Channel between the register front end and the instruction decoder.
// Assumes one clock domain; the decoder side is purely combinational.
`timescale 1ns/1ps
`default_nettype none
interface rsid_dec_if;
  import rsid_pkg::*;
  logic [XLEN-1:0]  instr;
  logic             br_taken;
  rsid_cls_e        cls;
  logic [OPC_W-1:0] opc;
  logic [REG_W-1:0] dest;
  logic [REG_W-1:0] src;
  rsid_size_e       size;
  logic [XLEN-1:0]  imm;
  logic             wb;
  logic             rot_n;
  logic             inv;
  logic             annul;
  logic             emul;
  logic             clrp;
  logic             uns;
  logic             ill;
  logic             resv_bad;
  modport dec (input instr, br_taken, output cls, opc, dest, src, size, imm, wb, rot_n, inv, annul,
               emul, clrp, uns, ill, resv_bad);
  modport host (output instr, br_taken, input cls, opc, dest, src, size, imm, wb, rot_n, inv, annul,
                emul, clrp, uns, ill, resv_bad);
endinterface
`default_nettype wire

// *** common/rsid_pkg.sv ***
// Constants and types of the short-immediate instruction decoder.
// Assumes a 32-bit instruction word and a 32-bit AHB-Lite register bus.
package rsid_pkg;

  localparam int XLEN     = 32;
  localparam int REG_W    = 5;
  localparam int IMM_W    = 15;
  localparam int OPC_W    = 7;
  localparam int SZ_W     = 2;
  localparam int CNT_W    = 16;
  localparam int ADDR_W   = 8;
  localparam int HTRANS_W = 2;
  localparam int HSIZE_W  = 3;
  localparam int GRP3_W   = 3;
  localparam int GRP4_W   = 4;
  localparam int GRP6_W   = 6;
  localparam int LOG_W    = 4;

  // Instruction field positions.
  localparam int DEST_LO = 27;
  localparam int SRC_LO  = 22;
  localparam int OPC_LO  = 15;
  localparam int EBIT    = 31;
  localparam int FBIT    = 31;
  localparam int MBIT    = 17;
  localparam int SZ_LO   = 15;
  localparam int ABIT    = 15;
  localparam int UBIT    = 15;
  localparam int IBIT    = 11;
  localparam int NBIT    = 10;

  // Opcodes and opcode groups, bits 21 down to 15.
  localparam logic [OPC_W-1:0]  OPC_ILLOP = 7'h00;
  localparam logic [OPC_W-1:0]  OPC_TRAP  = 7'h01;
  localparam logic [OPC_W-1:0]  OPC_CMND  = 7'h02;
  localparam logic [OPC_W-1:0]  OPC_RDCR  = 7'h04;
  localparam logic [OPC_W-1:0]  OPC_SWCR  = 7'h05;
  localparam logic [OPC_W-1:0]  OPC_BRCR  = 7'h06;
  localparam logic [OPC_W-1:0]  OPC_CMP   = 7'h50;
  localparam logic [GRP4_W-1:0] GRP_SHIFT = 4'h1;
  localparam logic [GRP3_W-1:0] GRP_LOGIC = 3'h1;
  localparam logic [15:0]       LOGIC_OPS = 16'h6bd6;
  localparam logic [GRP4_W-1:0] GRP_LD    = 4'h4;
  localparam logic [GRP4_W-1:0] GRP_LDU   = 4'h5;
  localparam logic [GRP4_W-1:0] GRP_ST    = 4'h6;
  localparam logic [GRP4_W-1:0] GRP_DC    = 4'h7;
  localparam logic [GRP6_W-1:0] BR_BSR    = 6'h20;
  localparam logic [GRP6_W-1:0] BR_JSR    = 6'h22;
  localparam logic [GRP6_W-1:0] BR_BBZ    = 6'h24;
  localparam logic [GRP6_W-1:0] BR_BBO    = 6'h25;
  localparam logic [GRP6_W-1:0] BR_BCND   = 6'h26;
  localparam logic [GRP6_W-1:0] GRP_ADD   = 6'h2c;
  localparam logic [GRP6_W-1:0] GRP_SUB   = 6'h2d;

  // Reserved-bit masks per instruction form.
  localparam logic [XLEN-1:0] RSV_TRAP  = 32'h7fc0_0000;
  localparam logic [XLEN-1:0] RSV_DSRC  = 32'hffc0_0000;
  localparam logic [XLEN-1:0] RSV_SRC   = 32'h07c0_0000;
  localparam logic [XLEN-1:0] RSV_SHIFT = 32'h0000_7000;
  localparam logic [XLEN-1:0] RSV_DC    = 32'h7800_0000;

  // Register byte offsets and bits.
  localparam logic [ADDR_W-1:0] REG_INSTR  = 8'h00;
  localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h04;
  localparam logic [ADDR_W-1:0] REG_CLASS  = 8'h08;
  localparam logic [ADDR_W-1:0] REG_FIELDS = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_IMM    = 8'h10;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h14;
  localparam int C_TAKEN    = 0;
  localparam int S_RSV      = 0;
  localparam int HT_ACT_BIT = 1;
  localparam logic [HSIZE_W-1:0] HSIZE_WORD = 3'h2;

  typedef enum logic [3:0] {
    CLS_ILLOP  = 4'h0,
    CLS_TRAP   = 4'h1,
    CLS_CMND   = 4'h2,
    CLS_CREG   = 4'h3,
    CLS_SHIFT  = 4'h4,
    CLS_LOGIC  = 4'h5,
    CLS_LOAD   = 4'h6,
    CLS_STORE  = 4'h7,
    CLS_DCACHE = 4'h8,
    CLS_BRANCH = 4'h9,
    CLS_CMP    = 4'ha,
    CLS_ADDSUB = 4'hb,
    CLS_UNDEF  = 4'hf
  } rsid_cls_e;

  typedef enum logic [SZ_W-1:0] {
    SZ_BYTE = 2'h0,
    SZ_HALF = 2'h1,
    SZ_WORD = 2'h2,
    SZ_DBL  = 2'h3
  } rsid_size_e;

endpackage

// *** rtl/rsid_decoder.sv ***
// Combinational decoder of one short-immediate instruction word.
// Assumes the word and the branch outcome are held stable by the front end.
`timescale 1ns/1ps
`default_nettype none
module rsid_decoder
  import rsid_pkg::*;
(
  // Decode channel.
  rsid_dec_if.dec d
);

  logic [XLEN-1:0]   w;
  logic [OPC_W-1:0]  op;
  logic [XLEN-1:0]   rsv;
  logic [XLEN-1:0]   simm;
  logic [GRP4_W-1:0] g4;
  logic [GRP6_W-1:0] g6;

  always_comb begin
    w          = d.instr;
    op         = w[OPC_LO +: OPC_W];
    g4         = op[OPC_W-1 -: GRP4_W];
    g6         = op[OPC_W-1 -: GRP6_W];
    rsv        = '0;
    simm       = {{(XLEN-IMM_W){w[IMM_W-1]}}, w[IMM_W-1:0]};
    d.opc      = op;
    d.dest     = w[DEST_LO +: REG_W];
    d.src      = w[SRC_LO +: REG_W];
    d.size     = rsid_size_e'(w[SZ_LO +: SZ_W]); // RULE4
    d.imm      = XLEN'(w[IMM_W-1:0]);
    d.cls      = CLS_UNDEF;
    d.wb       = 1'b0;
    d.rot_n    = 1'b0;
    d.inv      = 1'b0;
    d.annul    = 1'b0;
    d.emul     = 1'b0;
    d.clrp     = 1'b0;
    d.uns      = 1'b0;
    if (op == OPC_ILLOP) begin
      d.cls = CLS_ILLOP;
    end else if (op == OPC_TRAP) begin
      d.cls  = CLS_TRAP;
      d.emul = w[EBIT]; // RULE6
      rsv    = RSV_TRAP;
    end else if (op == OPC_CMND) begin
      d.cls = CLS_CMND;
      rsv   = RSV_DSRC;
    end else if (op == OPC_RDCR || op == OPC_SWCR || op == OPC_BRCR) begin
      // The immediate stays zero-extended: it names a control register.
      d.cls = CLS_CREG; // RULE7
      rsv   = (op == OPC_RDCR) ? RSV_SRC : (op == OPC_BRCR) ? RSV_DSRC : '0;
    end else if (g4 == GRP_SHIFT) begin
      d.cls   = CLS_SHIFT;
      d.rot_n = w[NBIT]; // RULE3
      d.inv   = w[IBIT];
      rsv     = RSV_SHIFT;
    end else if (op[OPC_W-1 -: GRP3_W] == GRP_LOGIC && LOGIC_OPS[op[LOG_W-1:0]]) begin
      d.cls = CLS_LOGIC;
    end else if (g4 == GRP_LD || g4 == GRP_LDU || g4 == GRP_ST) begin
      d.cls = (g4 == GRP_ST) ? CLS_STORE : CLS_LOAD;
      d.wb  = w[MBIT]; // RULE2
      d.uns = (g4 == GRP_LDU);
      d.imm = simm;
    end else if (g4 == GRP_DC && w[SZ_LO +: SZ_W] == '0) begin
      d.cls  = CLS_DCACHE;
      d.wb   = w[MBIT]; // RULE2
      d.clrp = w[FBIT]; // RULE8
      d.imm  = simm;
      rsv    = RSV_DC;
    end else if (g6 == BR_BSR || g6 == BR_JSR || g6 == BR_BBZ || g6 == BR_BBO || g6 == BR_BCND) begin
      d.cls   = CLS_BRANCH;
      d.annul = w[ABIT] & d.br_taken; // RULE5
      d.imm   = simm;
      rsv     = (g6 == BR_BSR) ? RSV_SRC : '0;
    end else if (op == OPC_CMP) begin
      d.cls = CLS_CMP;
      d.imm = simm;
    end else if (g6 == GRP_ADD || g6 == GRP_SUB) begin
      d.cls = CLS_ADDSUB;
      d.uns = w[UBIT]; // RULE9
      d.imm = simm;
    end
    d.ill      = (d.cls == CLS_UNDEF) || (d.cls == CLS_ILLOP);
    d.resv_bad = |(w & rsv); // RULE1
  end

endmodule
`default_nettype wire

// *** rtl/rsid_top.sv ***
// AHB-Lite front end of the short-immediate instruction decoder.
// Assumes one AHB-Lite master and single whole-word transfers on clk.
//
// What this block does
// RULE1 - Reserved instruction bits must be coded zero.
// RULE2 - Modify bit writes effective address back.
// RULE3 - Rotate-sense bit selects shift rotation direction.
// RULE4 - Size field: byte, halfword, word, doubleword.
// RULE5 - Annul bit cancels delay slot when taken.
// RULE6 - Emulation bit makes trap an emulation trap.
// RULE7 - Control-register forms give unsigned register number.
// RULE8 - Dcache flag clears sub-block present flags.
// RULE9 - Unsigned-form bit suppresses signed overflow.
//
// Implementation choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module rsid_top
  import rsid_pkg::*;
(
  // Clock and reset.
  input  wire logic                clk,
  input  wire logic                rst,
  // AHB-Lite slave.
  input  wire logic                hsel,
  input  wire logic [XLEN-1:0]     haddr,
  input  wire logic [HTRANS_W-1:0] htrans,
  input  wire logic                hwrite,
  input  wire logic [HSIZE_W-1:0]  hsize,
  input  wire logic                hready,
  input  wire logic [XLEN-1:0]     hwdata,
  output logic      [XLEN-1:0]     hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  // Decode strobes.
  output logic                     addr_wb,
  output logic                     delay_annul
);

  rsid_dec_if dif ();

  rsid_decoder u_dec (
    .d (dif.dec)
  );

  // Bus state.
  logic              dph_wr_r;
  logic              dph_wr_nxt;
  logic [ADDR_W-1:0] dph_addr_r;
  logic [ADDR_W-1:0] dph_addr_nxt;
  logic [XLEN-1:0]   hrdata_r;
  logic [XLEN-1:0]   hrdata_nxt;
  logic              hreadyout_r;
  logic              hresp_r;

  // Software-visible state.
  logic [XLEN-1:0]   instr_r;
  logic [XLEN-1:0]   instr_nxt;
  logic              taken_r;
  logic              taken_nxt;
  logic              resv_err_r;
  logic              resv_err_nxt;
  logic [CNT_W-1:0]  cnt_r;
  logic [CNT_W-1:0]  cnt_nxt;
  logic              dec_evt_r;
  logic              dec_evt_nxt;

  // Decode outputs.
  logic              wb_r;
  logic              wb_nxt;
  logic              annul_r;
  logic              annul_nxt;

  logic              acc;
  logic              wr_instr;
  logic              wr_ctrl;
  logic              wr_status;
  logic [XLEN-1:0]   rd_word;

  assign dif.instr    = instr_r;
  assign dif.br_taken = taken_r;

  assign hrdata      = hrdata_r;
  assign hreadyout   = hreadyout_r;
  assign hresp       = hresp_r;
  assign addr_wb     = wb_r;
  assign delay_annul = annul_r;

  // Read mux, driven by the decoder directly. A read whose address phase meets
  // the data phase of an instruction write still returns the old word and its
  // decode; one cycle later it sees the new ones.
  always_comb begin
    rd_word = '0;
    unique case (haddr[ADDR_W-1:0])
      REG_INSTR:  rd_word = instr_r;
      REG_CTRL:   rd_word = XLEN'(taken_r);
      REG_CLASS:  rd_word = XLEN'({dif.ill, dif.opc, dif.cls});
      REG_FIELDS: rd_word = XLEN'({dif.resv_bad, dif.inv, dif.uns, dif.clrp, dif.emul, dif.annul,
                                   dif.rot_n, dif.wb, dif.size, dif.src, dif.dest});
      REG_IMM:    rd_word = dif.imm; // RULE7
      REG_STATUS: rd_word = {cnt_r, {(XLEN-CNT_W-1){1'b0}}, resv_err_r};
      default:    rd_word = '0;
    endcase
  end

  // Address phase capture and data phase writes.
  always_comb begin
    acc          = hsel && htrans[HT_ACT_BIT] && hready;
    dph_wr_nxt   = acc && hwrite && (hsize == HSIZE_WORD);
    dph_addr_nxt = acc ? haddr[ADDR_W-1:0] : dph_addr_r;
    hrdata_nxt   = (acc && !hwrite) ? rd_word : '0;
    wr_instr     = dph_wr_r && (dph_addr_r == REG_INSTR);
    wr_ctrl      = dph_wr_r && (dph_addr_r == REG_CTRL);
    wr_status    = dph_wr_r && (dph_addr_r == REG_STATUS);
    instr_nxt    = wr_instr ? hwdata : instr_r;
    taken_nxt    = wr_ctrl ? hwdata[C_TAKEN] : taken_r;
    dec_evt_nxt  = wr_instr;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dph_wr_r    <= 1'b0;
      dph_addr_r  <= '0;
      hrdata_r    <= '0;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
      instr_r     <= '0;
      taken_r     <= 1'b0;
      dec_evt_r   <= 1'b0;
    end else begin
      dph_wr_r    <= dph_wr_nxt;
      dph_addr_r  <= dph_addr_nxt;
      hrdata_r    <= hrdata_nxt;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
      instr_r     <= instr_nxt;
      taken_r     <= taken_nxt;
      dec_evt_r   <= dec_evt_nxt;
    end
  end

  // Reserved-bit monitor and decode counter. A fresh violation in the cycle
  // of a write-one-to-clear keeps the flag set, so no event is lost.
  always_comb begin
    resv_err_nxt = resv_err_r;
    if (wr_status && hwdata[S_RSV]) begin
      resv_err_nxt = 1'b0;
    end
    if (dec_evt_r && dif.resv_bad) begin
      resv_err_nxt = 1'b1; // RULE1
    end
    cnt_nxt = dec_evt_r ? cnt_r + CNT_W'(1) : cnt_r;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      resv_err_r <= 1'b0;
      cnt_r      <= '0;
    end else begin
      resv_err_r <= resv_err_nxt;
      cnt_r      <= cnt_nxt;
    end
  end

  // Decode strobes toward the pipeline.
  always_comb begin
    wb_nxt    = dif.wb; // RULE2
    annul_nxt = dif.annul; // RULE5
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wb_r    <= 1'b0;
      annul_r <= 1'b0;
    end else begin
      wb_r    <= wb_nxt;
      annul_r <= annul_nxt;
    end
  end

  // Checks.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence instr_wr_s;
    wr_instr;
  endsequence

  sequence mem_dec_s;
    dec_evt_r && (dif.cls == CLS_LOAD || dif.cls == CLS_STORE || dif.cls == CLS_DCACHE);
  endsequence

  sequence taken_br_s;
    dec_evt_r && dif.cls == CLS_BRANCH && taken_r;
  endsequence

  property wb_follows_m_p;
    instr_wr_s ##1 mem_dec_s |=> addr_wb == $past(instr_r[MBIT]);
  endproperty

  property annul_taken_p;
    instr_wr_s ##1 taken_br_s |=> delay_annul == $past(instr_r[ABIT]);
  endproperty

  addr_writeback_a: assert property (wb_follows_m_p) // RULE2
    else $error("address write-back strobe does not follow the modify bit");

  delay_annul_a: assert property (annul_taken_p) // RULE5
    else $error("delay-slot annul does not follow the annul bit");

  no_annul_a: assert property (dec_evt_r && !taken_r |=> !delay_annul) // RULE5
    else $error("delay slot annulled although branch not taken");

  rotate_sense_a: assert property (dif.cls == CLS_SHIFT |-> dif.rot_n == instr_r[NBIT]) // RULE3
    else $error("rotate sense does not match bit 10");

  size_field_a: assert property ((dif.cls == CLS_LOAD || dif.cls == CLS_STORE) // RULE4
                                 |-> dif.size == rsid_size_e'(instr_r[SZ_LO +: SZ_W]))
    else $error("access size decode is wrong");

  emul_trap_a: assert property (dif.cls == CLS_TRAP |-> dif.emul == instr_r[EBIT] && !dif.ill) // RULE6
    else $error("emulation trap flag is wrong");

  creg_number_a: assert property ((instr_r[OPC_LO +: OPC_W] == OPC_RDCR) // RULE7
                                  |-> dif.cls == CLS_CREG && dif.imm == XLEN'(instr_r[IMM_W-1:0]))
    else $error("control register number is not the unsigned immediate");

  clear_present_a: assert property (dif.cls == CLS_DCACHE |-> dif.clrp == instr_r[FBIT]) // RULE8
    else $error("clear-present flag is wrong");

  unsigned_form_a: assert property (dif.cls == CLS_ADDSUB |-> dif.uns == instr_r[UBIT]) // RULE9
    else $error("unsigned form bit is wrong");

  // A clear written one cycle after the set may legally drop the flag.
  reserved_flag_a: assert property (dec_evt_r && dif.resv_bad // RULE1
                                    |=> resv_err_r ##1 (resv_err_r || $past(wr_status && hwdata[S_RSV])))
    else $error("reserved-bit violation not held");

  decode_count_a: assert property (dec_evt_r |=> cnt_r == $past(cnt_r) + CNT_W'(1))
    else $error("decode counter did not advance");

  // Bus-side checks. The slave never stalls, so every transfer is one address
  // cycle followed by one data cycle.
  sequence rd_addr_s;
    hsel && htrans[HT_ACT_BIT] && hready && !hwrite;
  endsequence

  sequence narrow_wr_s;
    hsel && htrans[HT_ACT_BIT] && hready && hwrite && (hsize != HSIZE_WORD);
  endsequence

  sequence flag_clr_s;
    wr_status && hwdata[S_RSV] && !(dec_evt_r && dif.resv_bad);
  endsequence

  property read_instr_p;
    rd_addr_s ##0 (haddr[ADDR_W-1:0] == REG_INSTR) |=> hrdata == $past(instr_r);
  endproperty

  property narrow_write_p;
    narrow_wr_s |=> ##1 (instr_r == $past(instr_r)) && (taken_r == $past(taken_r));
  endproperty

  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("slave inserted a wait state or an error response");

  read_instr_a: assert property (read_instr_p)
    else $error("read data does not carry the instruction word");

  read_idle_a: assert property (!(acc && !hwrite) |=> hrdata == '0)
    else $error("read data did not return to zero");

  instr_write_a: assert property (instr_wr_s |=> instr_r == $past(hwdata))
    else $error("instruction word write did not land");

  narrow_write_a: assert property (narrow_write_p)
    else $error("non-word write changed a register");

  taken_write_a: assert property (wr_ctrl |=> taken_r == $past(hwdata[C_TAKEN])) // RULE5
    else $error("branch outcome write did not land");

  flag_clear_a: assert property (flag_clr_s |=> !resv_err_r) // RULE1
    else $error("reserved-bit flag not cleared");

  count_hold_a: assert property (!dec_evt_r |=> cnt_r == $past(cnt_r))
    else $error("decode counter moved without a decode");

  // Decode checks that the bus alone shows only one word at a time.
  wb_mem_only_a: assert property (!(dif.cls inside {CLS_LOAD, CLS_STORE, CLS_DCACHE}) |-> !dif.wb) // RULE2
    else $error("write-back flagged outside loads, stores and cache operations");

  annul_branch_a: assert property (dif.cls != CLS_BRANCH |-> !dif.annul) // RULE5
    else $error("annul flagged outside branches");

  offset_sign_a: assert property ((dif.cls == CLS_LOAD || dif.cls == CLS_STORE)
                                  |-> dif.imm[XLEN-1:IMM_W] == {(XLEN-IMM_W){instr_r[IMM_W-1]}})
    else $error("memory offset is not sign-extended");

  creg_forms_a: assert property ((dif.opc == OPC_SWCR || dif.opc == OPC_BRCR) // RULE7
                                 |-> dif.cls == CLS_CREG && dif.imm == XLEN'(instr_r[IMM_W-1:0]))
    else $error("swap or branch form lost its control register number");

  trap_number_a: assert property (dif.cls == CLS_TRAP |-> dif.imm == XLEN'(instr_r[IMM_W-1:0]))
    else $error("trap number is not zero-extended");

  dcache_size_a: assert property ((instr_r[OPC_LO+OPC_W-GRP4_W +: GRP4_W] == GRP_DC)
                                  && (instr_r[SZ_LO +: SZ_W] != '0) |-> dif.ill)
    else $error("cache operation with nonzero size bits not flagged illegal");

endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench of the short-immediate decoder behind its AHB-Lite front end.
// Assumes the slave answers with zero wait states, so hready is tied to hreadyout.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import rsid_pkg::*;
();
  logic                clk    = 1'b0;
  logic                rst    = 1'b1;
  logic                hsel   = 1'b0;
  logic [XLEN-1:0]     haddr  = '0;
  logic [HTRANS_W-1:0] htrans = '0;
  logic                hwrite = 1'b0;
  logic [HSIZE_W-1:0]  hsize  = '0;
  logic [XLEN-1:0]     hwdata = '0;
  wire  logic          hready;
  logic [XLEN-1:0]     hrdata;
  logic                hreadyout;
  logic                hresp;
  logic                addr_wb;
  logic                delay_annul;
  int                  error_cnt  = 0;
  int                  n_compared = 0;
  int                  cyc        = 0;
  int                  n_wr       = 0;

  always #20 clk = ~clk;
  assign hready = hreadyout;

  rsid_top dut (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .addr_wb(addr_wb), .delay_annul(delay_annul)
  );

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [XLEN-1:0] seen, input logic [XLEN-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One whole transfer: address phase, then data phase; read data is taken at the closing edge.
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [XLEN-1:0] wd,
                     input logic [HSIZE_W-1:0] sz, output logic [XLEN-1:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= sz;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [XLEN-1:0] d);
    logic [XLEN-1:0] v;
    bus(1'b1, a, d, HSIZE_WORD, v);
  endtask

  task automatic rdv(input logic [ADDR_W-1:0] a, output logic [XLEN-1:0] v);
    bus(1'b0, a, 32'h0, HSIZE_WORD, v);
  endtask

  task automatic rdchk(input string what, input logic [ADDR_W-1:0] a, input logic [XLEN-1:0] e);
    logic [XLEN-1:0] v;
    rdv(a, v);
    chk(what, v, e);
  endtask

  // The decode strobes settle one edge after the write data lands.
  task automatic setins(input logic [XLEN-1:0] w);
    wr(REG_INSTR, w);
    n_wr++;
    repeat (2) @(posedge clk);
  endtask

  function automatic logic [XLEN-1:0] mk(input logic [REG_W-1:0] d, input logic [REG_W-1:0] s,
                                         input logic [OPC_W-1:0] o, input logic [IMM_W-1:0] i);
    return {d, s, o, i};
  endfunction

  function automatic logic [XLEN-1:0] cw(input logic [OPC_W-1:0] o, input logic [3:0] c);
    return {20'h0, 1'b0, o, c};
  endfunction

  task automatic t_reset();
    rdchk("instr", REG_INSTR, 32'h0000_0000);
    rdchk("ctrl", REG_CTRL, 32'h0000_0000);
    rdchk("class", REG_CLASS, 32'h0000_0800);
    rdchk("status", REG_STATUS, 32'h0000_0000);
    chk("addr_wb", {31'h0, addr_wb}, 32'h0);
    chk("delay_annul", {31'h0, delay_annul}, 32'h0);
    @(posedge clk);
    chk("hrdata idle", hrdata, 32'h0000_0000);
  endtask

  task automatic t_size();
    logic [XLEN-1:0] v;
    for (int s = 0; s < 4; s++) begin
      setins(mk(5'd3, 5'd7, {GRP_LD, 1'b0, 2'(s)}, 15'h4010));
      rdv(REG_FIELDS, v);
      chk("size", {30'h0, v[11:10]}, 32'(s));
      chk("dest src", {22'h0, v[9:0]}, {22'h0, 5'd7, 5'd3});
      rdchk("signed offset", REG_IMM, 32'hffff_c010);
      rdchk("load class", REG_CLASS, cw({GRP_LD, 1'b0, 2'(s)}, CLS_LOAD));
    end
  endtask

  task automatic t_wb();
    logic [GRP4_W-1:0] g[4] = '{GRP_LD, GRP_LDU, GRP_ST, GRP_DC};
    logic [XLEN-1:0]   v;
    for (int i = 0; i < 4; i++) begin
      for (int m = 0; m < 2; m++) begin
        setins(mk(5'd0, 5'd2, {g[i], 1'(m), 2'h0}, 15'h0008));
        chk("addr_wb", {31'h0, addr_wb}, 32'(m));
        rdv(REG_FIELDS, v);
        chk("wb field", {31'h0, v[12]}, 32'(m));
      end
    end
  endtask

  task automatic t_annul();
    logic [GRP6_W-1:0] b[5] = '{BR_BSR, BR_JSR, BR_BBZ, BR_BBO, BR_BCND};
    for (int i = 0; i < 5; i++) begin
      for (int t = 0; t < 2; t++) begin
        for (int a = 0; a < 2; a++) begin
          wr(REG_CTRL, 32'(t));
          setins(mk(5'd0, 5'd0, {b[i], 1'(a)}, 15'h7ff0));
          chk("delay_annul", {31'h0, delay_annul}, 32'(a & t));
        end
      end
    end
    // A branch outcome flipped to not-taken must withdraw the cancel.
    wr(REG_CTRL, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk("delay_annul", {31'h0, delay_annul}, 32'h0);
  endtask

  task automatic t_flags();
    logic [XLEN-1:0] base[5] = '{mk(5'd1, 5'd2, {GRP_SHIFT, 3'h0}, 15'h0), mk(5'd0, 5'd0, OPC_TRAP, 15'h5),
                                 mk(5'd0, 5'd2, {GRP_DC, 3'h0}, 15'h0), mk(5'd1, 5'd2, {GRP_ADD, 1'b0}, 15'h0),
                                 mk(5'd1, 5'd2, {GRP_SUB, 1'b0}, 15'h0)};
    logic [XLEN-1:0] set[5]  = '{32'h0000_0400, 32'h8000_0000, 32'h8000_0000, 32'h0000_8000, 32'h0000_8000};
    int              fb[5]   = '{13, 15, 16, 17, 17};
    logic [3:0]      cl[5]   = '{CLS_SHIFT, CLS_TRAP, CLS_DCACHE, CLS_ADDSUB, CLS_ADDSUB};
    logic [XLEN-1:0] v;
    for (int i = 0; i < 5; i++) begin
      for (int k = 0; k < 2; k++) begin
        setins(base[i] | (k ? set[i] : 32'h0));
        rdv(REG_FIELDS, v);
        chk("modifier bit", {31'h0, v[fb[i]]}, 32'(k));
        rdv(REG_CLASS, v);
        chk("class", {28'h0, v[3:0]}, {28'h0, cl[i]});
      end
    end
  endtask

  task automatic t_creg();
    logic [OPC_W-1:0] o[3] = '{OPC_RDCR, OPC_SWCR, OPC_BRCR};
    for (int i = 0; i < 3; i++) begin
      setins(mk(5'd0, 5'd0, o[i], 15'h4010));
      rdchk("creg class", REG_CLASS, cw(o[i], CLS_CREG));
      rdchk("creg number", REG_IMM, 32'h0000_4010);
    end
  endtask

  task automatic t_resv();
    logic [XLEN-1:0] v;
    setins(mk(5'd0, 5'd1, OPC_TRAP, 15'h0));
    rdchk("reserved flag", REG_STATUS, {16'(n_wr), 16'h0001});
    rdchk("trap class", REG_CLASS, cw(OPC_TRAP, CLS_TRAP));
    setins(mk(5'd0, 5'd0, OPC_TRAP, 15'h0));
    rdchk("sticky flag", REG_STATUS, {16'(n_wr), 16'h0001});
    wr(REG_STATUS, 32'h0000_0001);
    rdchk("flag cleared", REG_STATUS, {16'(n_wr), 16'h0000});
    // A byte write must leave the instruction word untouched.
    bus(1'b1, REG_INSTR, 32'hffff_ffff, 3'h0, v);
    rdchk("instr after byte write", REG_INSTR, mk(5'd0, 5'd0, OPC_TRAP, 15'h0));
    wr(8'h18, 32'hffff_ffff);
    rdchk("unmapped", 8'h18, 32'h0000_0000);
  endtask

  // Logic, compare, command and the undefined forms; only the command word breaks reserved bits.
  task automatic t_class();
    logic [XLEN-1:0] w[5]  = '{mk(5'd1, 5'd2, {GRP_LOGIC, 4'h6}, 15'h4010), mk(5'd1, 5'd2, {GRP_LOGIC, 4'h0}, 15'h4010),
                               mk(5'd1, 5'd2, OPC_CMP, 15'h4010), mk(5'd1, 5'd0, OPC_CMND, 15'h4010),
                               mk(5'd0, 5'd2, {GRP_DC, 3'h1}, 15'h4010)};
    logic [3:0]      cl[5] = '{CLS_LOGIC, CLS_UNDEF, CLS_CMP, CLS_CMND, CLS_UNDEF};
    logic [XLEN-1:0] im[5] = '{32'h0000_4010, 32'h0000_4010, 32'hffff_c010, 32'h0000_4010, 32'h0000_4010};
    logic [XLEN-1:0] v;
    for (int i = 0; i < 5; i++) begin
      setins(w[i]);
      rdchk("class word", REG_CLASS, {20'h0, cl[i] == CLS_UNDEF, w[i][OPC_LO +: OPC_W], cl[i]});
      rdchk("immediate", REG_IMM, im[i]);
      rdv(REG_FIELDS, v);
      chk("reserved bit", {31'h0, v[19]}, {31'h0, i == 3});
    end
  endtask

  // A reset in mid-run must return the instruction, control and status registers and the addr_wb strobe to zero.
  task automatic t_rerst();
    wr(REG_CTRL, 32'h0000_0001);
    setins(mk(5'd0, 5'd2, {GRP_LD, 3'h4}, 15'h0008));
    chk("addr_wb before reset", {31'h0, addr_wb}, 32'h1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("addr_wb after reset", {31'h0, addr_wb}, 32'h0);
    rdchk("instr after reset", REG_INSTR, 32'h0000_0000);
    rdchk("ctrl after reset", REG_CTRL, 32'h0000_0000);
    rdchk("status after reset", REG_STATUS, 32'h0000_0000);
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      finish_test();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    chk("ready in reset", {31'h0, hreadyout}, 32'h1);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_size();
    t_wb();
    t_annul();
    t_flags();
    t_creg();
    t_class();
    t_resv();
    t_rerst();
    finish_test();
  end
endmodule
`default_nettype wire
